/* rtl/ccrw_pkg.sv */
// Purpose: Shared constants and types of the calendar clock block
// Assumes: 32-bit AXI4-Lite data, 16-bit registers in the low half-word
// Notes:   Struct field order matches the register bit order
package ccrw_pkg;

	// ********************************************************
	// Register map (byte addresses)
	// ********************************************************
	localparam logic [7:0] ADDR_CONFIG    = 8'h00;
	localparam logic [7:0] ADDR_VALUE     = 8'h04;
	localparam logic [7:0] ADDR_ALARM_CFG = 8'h08;
	localparam logic [7:0] ADDR_ALARM_VAL = 8'h0c;
	localparam logic [7:0] ADDR_KEY       = 8'h10;

	// ********************************************************
	// Field positions and values
	// ********************************************************
	localparam int         CFG_ENABLE_BIT = 15;
	localparam int         CFG_WREN_BIT   = 13;
	localparam int         CFG_RIPPLE_BIT = 12;
	localparam int         CFG_HALF_BIT   = 11;
	localparam int         CFG_OE_BIT     = 10;
	localparam logic [7:0] KEY_FIRST      = 8'h55;
	localparam logic [7:0] KEY_SECOND     = 8'haa;
	localparam logic [1:0] RESP_OKAY      = 2'b00;
	localparam logic [1:0] RESP_SLVERR    = 2'b10;
	localparam logic [1:0] PTR_MIN_SEC    = 2'b00;
	localparam logic [1:0] PTR_WD_HR      = 2'b01;
	localparam logic [1:0] PTR_MON_DAY    = 2'b10;
	localparam logic [1:0] PTR_YEAR       = 2'b11;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int         REF_HZ         = 32768;
	localparam int         RIPPLE_TICKS   = 32;

	// ********************************************************
	// Alarm interval codes
	// ********************************************************
	localparam logic [3:0] AL_HALF_SEC    = 4'h0;
	localparam logic [3:0] AL_SECOND      = 4'h1;
	localparam logic [3:0] AL_TEN_SEC     = 4'h2;
	localparam logic [3:0] AL_MINUTE      = 4'h3;
	localparam logic [3:0] AL_TEN_MIN     = 4'h4;
	localparam logic [3:0] AL_HOUR        = 4'h5;
	localparam logic [3:0] AL_DAY         = 4'h6;
	localparam logic [3:0] AL_WEEK        = 4'h7;
	localparam logic [3:0] AL_MONTH       = 4'h8;
	localparam logic [3:0] AL_YEAR        = 4'h9;

	// ********************************************************
	// Reset values and BCD limits
	// ********************************************************
	localparam logic [15:0] CFG_RESET     = 16'h0000;
	localparam logic [15:0] ALARM_RESET   = 16'h0000;
	localparam logic [7:0]  BCD_ZERO      = 8'h00;
	localparam logic [7:0]  BCD_ONE       = 8'h01;
	localparam logic [7:0]  BCD_59        = 8'h59;
	localparam logic [7:0]  BCD_23        = 8'h23;
	localparam logic [7:0]  BCD_12        = 8'h12;
	localparam logic [7:0]  BCD_99        = 8'h99;
	localparam logic [2:0]  WDAY_LAST     = 3'h6;

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic       enable;
		logic       wren;
		logic       oe;
		logic [1:0] ptr;
		logic [7:0] trim;
	} ccrw_cfg_s;

	typedef struct packed {
		logic       enable;
		logic       chime;
		logic [3:0] interval;
		logic [1:0] ptr;
		logic [7:0] repeat_count;
	} ccrw_alarm_cfg_s;

	typedef struct packed {
		logic [7:0] mon;
		logic [7:0] day;
		logic [2:0] wd;
		logic [7:0] hr;
		logic [7:0] min;
		logic [7:0] sec;
	} ccrw_time_s;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_ARMED
	} ccrw_key_e;

endpackage : ccrw_pkg

/* rtl/ccrw_bcd2.sv */
// Purpose: Two-digit BCD counter with load and carry
// Assumes: Values are valid BCD
// Notes:   Carry is combinational so a cascade ripples in one cycle
`timescale 1ns/1ps
`default_nettype none
module ccrw_bcd2 #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Control
	input  wire logic       inc,
	input  wire logic       load,
	input  wire logic [7:0] load_val,
	input  wire logic [7:0] lo,
	input  wire logic [7:0] hi,
	// Result
	output logic [7:0]      val,
	output logic            carry
);
	logic [7:0] next_val;

	always_comb
	begin
		carry    = inc && (val >= hi);
		next_val = val;
		if (load)
			next_val = load_val;
		else if (inc)
		begin
			if (val >= hi)
				next_val = lo;
			else if (val[3:0] == 4'h9)
				next_val = {val[7:4] + 4'h1, 4'h0};
			else
				next_val = {val[7:4], val[3:0] + 4'h1};
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			val <= RESET_VAL;
		else
			val <= next_val;
	end
endmodule : ccrw_bcd2
`default_nettype wire

/* rtl/ccrw_top.sv */
// Purpose: Calendar clock with alarm, trim and register windows, only the value window locked
// Assumes: Reference ticks are one-cycle pulses synchronous to aclk
// Notes:   aresetn is the power-on reset; pin reset spares the calendar
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Fuse picks crystal or internal oscillator
// - Calendar keeps counting through pin reset
// - Value pointer selects shown counter pair
// - Value high write decrements pointer, saturating
// - Alarm pointer selects shown alarm pair
// - Alarm high write decrements pointer, saturating
// - Window reads decrement; low writes do not
// - Value writes ignored while write enable clear
// - Write enable set only after key sequence
// - Module enable bit, writable only when unlocked
// - Ripple status flags unsafe read moments
// - Half-second phase bit, cleared on seconds write
// - Output enable bit gates clock pin
// - Signed trim adds or drops four ticks/minute per step
// - Configuration register cleared by power-on only
// - BCD 24-hour calendar with leap years
// - Alarm intervals, repeat counter and chime
// - Four-bit interval codes, reserved codes never fire
// - Repeat counter decrements, wraps only with chime
// - Alarm enable self-clears at zero without chime
module ccrw_top #(
	parameter int TICKS_PER_SEC = ccrw_pkg::REF_HZ
) (
	// Clock and power-on reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Device reset pin and clock source
	input  wire logic        external_pin_reset,
	input  wire logic        clock_source_fuse,
	input  wire logic        secondary_crystal_osc_tick,
	input  wire logic        low_power_internal_osc_tick,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pin and event
	output logic             clock_out,
	output logic             alarm_event
);
	localparam logic signed [16:0] P_LAST = 17'(TICKS_PER_SEC - 1);
	localparam logic signed [16:0] P_HALF = 17'(TICKS_PER_SEC / 2);
	localparam logic signed [16:0] P_SYNC =
		17'(TICKS_PER_SEC - ccrw_pkg::RIPPLE_TICKS);

	// ********************************************************
	// State
	// ********************************************************
	ccrw_pkg::ccrw_cfg_s       cfg,      next_cfg;
	ccrw_pkg::ccrw_alarm_cfg_s acfg,     next_acfg;
	ccrw_pkg::ccrw_time_s      aval,     next_aval;
	ccrw_pkg::ccrw_key_e       key,      next_key;
	logic [2:0]                wday,     next_wday;
	logic signed [16:0]        presc,    next_presc;
	logic                      tick_d,   next_tick_d;
	logic                      half_d,   next_half_d;
	logic                      wr_rdy,   next_wr_rdy;
	logic                      b_valid,  next_b_valid;
	logic [1:0]                b_resp,   next_b_resp;
	logic                      ar_rdy,   next_ar_rdy;
	logic                      r_valid,  next_r_valid;
	logic [31:0]               r_data,   next_r_data;
	logic [1:0]                r_resp,   next_r_resp;
	logic                      clk_q,    next_clk_q;
	logic                      alarm_q,  next_alarm_q;

	// ********************************************************
	// Decode and calendar wires
	// ********************************************************
	logic        wr_go, rd_go, val_wr, wr_hi, wr_lo;
	logic [15:0] wd16, rd_word;
	logic        ref_tick, sec_tick, half_tick, half_phase, ripple, leap;
	logic        ld_sec, ld_min, ld_hr, ld_wd, ld_day, ld_mon, ld_yr;
	logic        c_sec, c_min, c_hr, c_day, c_mon;
	logic [7:0]  sec, min, hr, day, mon, yr, day_max;
	logic        alarm_hit, alarm_fire, rd_value, rd_alarm;
	logic        m_s1, m_s, m_m1, m_m, m_h, m_w, m_d, m_mo;

	assign wr_go  = wr_rdy && s_axi_awvalid && s_axi_wvalid;
	assign rd_go  = ar_rdy && s_axi_arvalid;
	assign wd16   = s_axi_wdata[15:0];
	assign wr_hi  = s_axi_wstrb[1];
	assign wr_lo  = s_axi_wstrb[0];
	assign val_wr = wr_go && s_axi_awaddr == ccrw_pkg::ADDR_VALUE
		&& cfg.wren;
	assign ld_sec = val_wr && cfg.ptr == ccrw_pkg::PTR_MIN_SEC && wr_lo;
	assign ld_min = val_wr && cfg.ptr == ccrw_pkg::PTR_MIN_SEC && wr_hi;
	assign ld_hr  = val_wr && cfg.ptr == ccrw_pkg::PTR_WD_HR && wr_lo;
	assign ld_wd  = val_wr && cfg.ptr == ccrw_pkg::PTR_WD_HR && wr_hi;
	assign ld_day = val_wr && cfg.ptr == ccrw_pkg::PTR_MON_DAY && wr_lo;
	assign ld_mon = val_wr && cfg.ptr == ccrw_pkg::PTR_MON_DAY && wr_hi;
	assign ld_yr  = val_wr && cfg.ptr == ccrw_pkg::PTR_YEAR && wr_lo;
	assign rd_value = rd_go && s_axi_araddr == ccrw_pkg::ADDR_VALUE;
	assign rd_alarm = rd_go && s_axi_araddr == ccrw_pkg::ADDR_ALARM_VAL;

	// ********************************************************
	// Time base
	// ********************************************************
	assign ref_tick = cfg.enable && (clock_source_fuse ?
		secondary_crystal_osc_tick : low_power_internal_osc_tick);
	assign sec_tick   = ref_tick && presc == P_LAST;
	assign half_tick  = ref_tick && presc == P_HALF - 17'sd1;
	assign half_phase = presc >= P_HALF;
	assign ripple     = presc >= P_SYNC;

	// ********************************************************
	// Calendar counters
	// ********************************************************
	assign leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
		: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);

	always_comb
	begin
		case (mon)
			8'h02:   day_max = leap ? 8'h29 : 8'h28;
			8'h04,
			8'h06,
			8'h09,
			8'h11:   day_max = 8'h30;
			default: day_max = 8'h31;
		endcase
	end

	ccrw_bcd2 #(.RESET_VAL(ccrw_pkg::BCD_ZERO)) u_sec (
		.aclk(aclk), .aresetn(aresetn), .inc(sec_tick), .load(ld_sec),
		.load_val(wd16[7:0]), .lo(ccrw_pkg::BCD_ZERO),
		.hi(ccrw_pkg::BCD_59), .val(sec), .carry(c_sec));
	ccrw_bcd2 #(.RESET_VAL(ccrw_pkg::BCD_ZERO)) u_min (
		.aclk(aclk), .aresetn(aresetn), .inc(c_sec), .load(ld_min),
		.load_val(wd16[15:8]), .lo(ccrw_pkg::BCD_ZERO),
		.hi(ccrw_pkg::BCD_59), .val(min), .carry(c_min));
	ccrw_bcd2 #(.RESET_VAL(ccrw_pkg::BCD_ZERO)) u_hr (
		.aclk(aclk), .aresetn(aresetn), .inc(c_min), .load(ld_hr),
		.load_val(wd16[7:0]), .lo(ccrw_pkg::BCD_ZERO),
		.hi(ccrw_pkg::BCD_23), .val(hr), .carry(c_hr));
	ccrw_bcd2 #(.RESET_VAL(ccrw_pkg::BCD_ONE)) u_day (
		.aclk(aclk), .aresetn(aresetn), .inc(c_hr), .load(ld_day),
		.load_val(wd16[7:0]), .lo(ccrw_pkg::BCD_ONE),
		.hi(day_max), .val(day), .carry(c_day));
	ccrw_bcd2 #(.RESET_VAL(ccrw_pkg::BCD_ONE)) u_mon (
		.aclk(aclk), .aresetn(aresetn), .inc(c_day), .load(ld_mon),
		.load_val(wd16[15:8]), .lo(ccrw_pkg::BCD_ONE),
		.hi(ccrw_pkg::BCD_12), .val(mon), .carry(c_mon));
	ccrw_bcd2 #(.RESET_VAL(ccrw_pkg::BCD_ZERO)) u_yr (
		.aclk(aclk), .aresetn(aresetn), .inc(c_mon), .load(ld_yr),
		.load_val(wd16[7:0]), .lo(ccrw_pkg::BCD_ZERO),
		.hi(ccrw_pkg::BCD_99), .val(yr), .carry());

	// ********************************************************
	// Alarm match
	// ********************************************************
	always_comb
	begin
		m_s1 = sec[3:0] == aval.sec[3:0];
		m_s  = sec == aval.sec;
		m_m1 = m_s && min[3:0] == aval.min[3:0];
		m_m  = m_s && min == aval.min;
		m_h  = m_m && hr == aval.hr;
		m_w  = m_h && wday == aval.wd;
		m_d  = m_h && day == aval.day;
		m_mo = m_d && mon == aval.mon;
		case (acfg.interval)
			ccrw_pkg::AL_HALF_SEC: alarm_hit = tick_d || half_d;
			ccrw_pkg::AL_SECOND:   alarm_hit = tick_d;
			ccrw_pkg::AL_TEN_SEC:  alarm_hit = tick_d && m_s1;
			ccrw_pkg::AL_MINUTE:   alarm_hit = tick_d && m_s;
			ccrw_pkg::AL_TEN_MIN:  alarm_hit = tick_d && m_m1;
			ccrw_pkg::AL_HOUR:     alarm_hit = tick_d && m_m;
			ccrw_pkg::AL_DAY:      alarm_hit = tick_d && m_h;
			ccrw_pkg::AL_WEEK:     alarm_hit = tick_d && m_w;
			ccrw_pkg::AL_MONTH:    alarm_hit = tick_d && m_d;
			ccrw_pkg::AL_YEAR:     alarm_hit = tick_d && m_mo;
			default:               alarm_hit = 1'b0;
		endcase
	end
	assign alarm_fire = alarm_hit && acfg.enable && cfg.enable;

	// ********************************************************
	// Read mux
	// ********************************************************
	always_comb
	begin
		rd_word = 16'h0000;
		case (s_axi_araddr)
			ccrw_pkg::ADDR_CONFIG:
				rd_word = {cfg.enable, 1'b0, cfg.wren, ripple, half_phase,
					cfg.oe, cfg.ptr, cfg.trim};
			ccrw_pkg::ADDR_VALUE:
				case (cfg.ptr)
					ccrw_pkg::PTR_MIN_SEC: rd_word = {min, sec};
					ccrw_pkg::PTR_WD_HR:   rd_word = {5'h00, wday, hr};
					ccrw_pkg::PTR_MON_DAY: rd_word = {mon, day};
					default:               rd_word = {8'h00, yr};
				endcase
			ccrw_pkg::ADDR_ALARM_CFG:
				rd_word = acfg;
			ccrw_pkg::ADDR_ALARM_VAL:
				case (acfg.ptr)
					ccrw_pkg::PTR_MIN_SEC: rd_word = {aval.min, aval.sec};
					ccrw_pkg::PTR_WD_HR:   rd_word = {5'h00, aval.wd, aval.hr};
					ccrw_pkg::PTR_MON_DAY: rd_word = {aval.mon, aval.day};
					default:               rd_word = 16'h0000;
				endcase
			default:
				rd_word = 16'h0000;
		endcase
	end

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb
	begin
		next_cfg     = cfg;
		next_acfg    = acfg;
		next_aval    = aval;
		next_key     = key;
		next_wday    = wday;
		next_presc   = presc;
		next_tick_d  = sec_tick;
		next_half_d  = half_tick;
		next_clk_q   = cfg.oe && cfg.enable && !half_phase;
		next_alarm_q = alarm_fire;
		next_wr_rdy  = !wr_rdy && s_axi_awvalid && s_axi_wvalid && !b_valid;
		next_ar_rdy  = !ar_rdy && s_axi_arvalid && !r_valid;
		next_b_valid = b_valid && !s_axi_bready;
		next_b_resp  = b_resp;
		next_r_valid = r_valid && !s_axi_rready;
		next_r_data  = r_data;
		next_r_resp  = r_resp;

		// Prescaler with once-a-minute trim
		if (ld_sec)
			next_presc = 17'sd0;
		else if (sec_tick)
			next_presc = c_sec ? {{7{cfg.trim[7]}}, cfg.trim, 2'b00}
				: 17'sd0;
		else if (ref_tick)
			next_presc = presc + 17'sd1;

		// Weekday follows the day roll
		if (ld_wd)
			next_wday = wd16[10:8];
		else if (c_hr)
			next_wday = (wday >= ccrw_pkg::WDAY_LAST) ? 3'h0 : wday + 3'h1;

		// Alarm repeat and self-clear
		if (alarm_fire)
		begin
			if (acfg.repeat_count != 8'h00)
				next_acfg.repeat_count = acfg.repeat_count - 8'h01;
			else if (acfg.chime)
				next_acfg.repeat_count = 8'hff;
			else
				next_acfg.enable = 1'b0;
		end

		// Window pointer walk
		if ((val_wr && wr_hi) || rd_value)
			if (cfg.ptr != 2'b00)
				next_cfg.ptr = cfg.ptr - 2'b01;
		if ((wr_go && s_axi_awaddr == ccrw_pkg::ADDR_ALARM_VAL && wr_hi)
			|| rd_alarm)
			if (acfg.ptr != 2'b00)
				next_acfg.ptr = acfg.ptr - 2'b01;

		// Register writes
		if (wr_go)
		begin
			next_b_valid = 1'b1;
			next_b_resp  = ccrw_pkg::RESP_OKAY;
			if (key == ccrw_pkg::KEY_ARMED)
				next_key = ccrw_pkg::KEY_IDLE;
			case (s_axi_awaddr)
				ccrw_pkg::ADDR_CONFIG:
				begin
					if (wr_hi)
					begin
						if (cfg.wren)
							next_cfg.enable = wd16[ccrw_pkg::CFG_ENABLE_BIT];
						if (!wd16[ccrw_pkg::CFG_WREN_BIT])
							next_cfg.wren = 1'b0;
						else if (key == ccrw_pkg::KEY_ARMED)
							next_cfg.wren = 1'b1;
						next_cfg.oe  = wd16[ccrw_pkg::CFG_OE_BIT];
						next_cfg.ptr = wd16[9:8];
					end
					if (wr_lo)
						next_cfg.trim = wd16[7:0];
				end
				ccrw_pkg::ADDR_VALUE:
				begin
				end
				ccrw_pkg::ADDR_ALARM_CFG:
				begin
					if (wr_hi)
						next_acfg[15:8] = wd16[15:8];
					if (wr_lo)
						next_acfg.repeat_count = wd16[7:0];
				end
				ccrw_pkg::ADDR_ALARM_VAL:
					case (acfg.ptr)
						ccrw_pkg::PTR_MIN_SEC:
						begin
							if (wr_hi)
								next_aval.min = wd16[15:8];
							if (wr_lo)
								next_aval.sec = wd16[7:0];
						end
						ccrw_pkg::PTR_WD_HR:
						begin
							if (wr_hi)
								next_aval.wd = wd16[10:8];
							if (wr_lo)
								next_aval.hr = wd16[7:0];
						end
						ccrw_pkg::PTR_MON_DAY:
						begin
							if (wr_hi)
								next_aval.mon = wd16[15:8];
							if (wr_lo)
								next_aval.day = wd16[7:0];
						end
						default:
						begin
						end
					endcase
				ccrw_pkg::ADDR_KEY:
					if (wr_lo && wd16[7:0] == ccrw_pkg::KEY_FIRST)
						next_key = ccrw_pkg::KEY_GOT_FIRST;
					else if (wr_lo && key == ccrw_pkg::KEY_GOT_FIRST
						&& wd16[7:0] == ccrw_pkg::KEY_SECOND)
						next_key = ccrw_pkg::KEY_ARMED;
					else
						next_key = ccrw_pkg::KEY_IDLE;
				default:
					next_b_resp = ccrw_pkg::RESP_SLVERR;
			endcase
		end

		// Register reads
		if (rd_go)
		begin
			next_r_valid = 1'b1;
			next_r_data  = {16'h0000, rd_word};
			case (s_axi_araddr)
				ccrw_pkg::ADDR_CONFIG,
				ccrw_pkg::ADDR_VALUE,
				ccrw_pkg::ADDR_ALARM_CFG,
				ccrw_pkg::ADDR_ALARM_VAL,
				ccrw_pkg::ADDR_KEY: next_r_resp = ccrw_pkg::RESP_OKAY;
				default:            next_r_resp = ccrw_pkg::RESP_SLVERR;
			endcase
		end

		// Pin reset clears only the unlock sequence
		if (external_pin_reset)
			next_key = ccrw_pkg::KEY_IDLE;
	end

	// ********************************************************
	// Registers
	// ********************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg     <= {ccrw_pkg::CFG_RESET[15], ccrw_pkg::CFG_RESET[13],
				ccrw_pkg::CFG_RESET[10:0]};
			acfg    <= ccrw_pkg::ALARM_RESET;
			aval    <= '0;
			key     <= ccrw_pkg::KEY_IDLE;
			wday    <= 3'h0;
			presc   <= 17'sd0;
			tick_d  <= 1'b0;
			half_d  <= 1'b0;
			wr_rdy  <= 1'b0;
			b_valid <= 1'b0;
			b_resp  <= ccrw_pkg::RESP_OKAY;
			ar_rdy  <= 1'b0;
			r_valid <= 1'b0;
			r_data  <= 32'h0000_0000;
			r_resp  <= ccrw_pkg::RESP_OKAY;
			clk_q   <= 1'b0;
			alarm_q <= 1'b0;
		end
		else
		begin
			cfg     <= next_cfg;
			acfg    <= next_acfg;
			aval    <= next_aval;
			key     <= next_key;
			wday    <= next_wday;
			presc   <= next_presc;
			tick_d  <= next_tick_d;
			half_d  <= next_half_d;
			wr_rdy  <= next_wr_rdy;
			b_valid <= next_b_valid;
			b_resp  <= next_b_resp;
			ar_rdy  <= next_ar_rdy;
			r_valid <= next_r_valid;
			r_data  <= next_r_data;
			r_resp  <= next_r_resp;
			clk_q   <= next_clk_q;
			alarm_q <= next_alarm_q;
		end
	end

	assign s_axi_awready = wr_rdy;
	assign s_axi_wready  = wr_rdy;
	assign s_axi_bvalid  = b_valid;
	assign s_axi_bresp   = b_resp;
	assign s_axi_arready = ar_rdy;
	assign s_axi_rvalid  = r_valid;
	assign s_axi_rdata   = r_data;
	assign s_axi_rresp   = r_resp;
	assign clock_out     = clk_q;
	assign alarm_event   = alarm_q;
endmodule : ccrw_top
`default_nettype wire

/* verification/ccrw_checker.sv */
// Purpose: Port checks of ccrw_top
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound from the bench file
`timescale 1ns/1ps
`default_nettype none
module ccrw_checker (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus and event
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rready,
	input wire logic        alarm_event
);
	// ******
	// Checks
	// ******
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_ready_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("ready pair split");
	a_aw_cause: assert property (s_axi_awready |->
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) else $error("aw early");
	a_aw_answer: assert property (s_axi_awready |=>
		!s_axi_awready && s_axi_bvalid) else $error("no write answer");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	a_ar_answer: assert property (s_axi_arready |=>
		!s_axi_arready && s_axi_rvalid) else $error("no read answer");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	a_r_upper: assert property (s_axi_rvalid |->
		s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
	a_event_pulse: assert property (alarm_event |=> !alarm_event)
		else $error("event too long");
	c_event: cover property (alarm_event);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ccrw_checker
`default_nettype wire

/* verification/ccrw_top_tb.sv */
// Purpose: Self-checking bench of ccrw_top
// Assumes: TICKS_PER_SEC of 64
// Notes:   Crystal tick every 2 cycles, internal every 4
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	mismatches++; $display("Error %s exp %h got %h", n, e, g); end end
module ccrw_top_tb;
	// ******
	// Bench
	// ******
	logic        aclk = 1'h0, aresetn = 1'h0, alarm_event, clock_out;
	logic        external_pin_reset = 1'h0, clock_source_fuse = 1'h1;
	logic        secondary_crystal_osc_tick = 1'h0;
	logic        low_power_internal_osc_tick = 1'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h1;
	logic        s_axi_rready = 1'h1, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  tk = 2'h0, s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	int          mismatches = 0, cmp_count = 0, evc = 0, n;
	logic [15:0] rd_last, rd_prev;
	ccrw_top #(.TICKS_PER_SEC(64)) dut_u (.*);
	always #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		tk <= tk + 2'h1;
		secondary_crystal_osc_tick <= tk[0];
		low_power_internal_osc_tick <= (tk == 2'h3);
		evc <= evc + int'(alarm_event === 1'h1);
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] v,
		input logic [3:0] s = 4'h3, input logic [1:0] r = 2'h0);
		repeat (2) @(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 16'h0000, v, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h6;
		do @(negedge aclk); while (s_axi_awready !== 1'h1);
		@(posedge aclk);
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
		`CHK("bresp", r, s_axi_bresp)
		@(posedge aclk);
		s_axi_bready <= 1'h1;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [15:0] e,
		input logic [15:0] m = 16'hffff, input logic [1:0] r = 2'h0);
		repeat (2) @(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h2};
		do @(negedge aclk); while (s_axi_arready !== 1'h1);
		@(posedge aclk);
		s_axi_arvalid <= 1'h0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
		`CHK("rresp", r, s_axi_rresp)
		`CHK("rdata", e, s_axi_rdata[15:0] & m)
		rd_last = s_axi_rdata[15:0];
		@(posedge aclk);
		s_axi_rready <= 1'h1;
	endtask : rc
	task automatic hi_len(output int c);
		c = 0;
		do @(negedge aclk); while (clock_out !== 1'h0);
		do @(negedge aclk); while (clock_out !== 1'h1);
		for (; clock_out === 1'h1; c++) @(negedge aclk);
	endtask : hi_len
	task automatic unlock(input logic [15:0] c);
		wr(8'h10, 16'h0055, 4'h1);
		wr(8'h10, 16'h00aa, 4'h1);
		wr(8'h00, c);
	endtask : unlock
	task automatic t_lock;
		rc(8'h00, 16'h0000);
		rc(8'h14, 16'h0000, 16'hffff, 2'h2);
		wr(8'h14, 16'h1234, 4'h3, 2'h2);
		wr(8'h04, 16'h1234);
		rc(8'h04, 16'h0000);
		wr(8'h00, 16'ha000);
		rc(8'h00, 16'h0000);
	endtask : t_lock
	task automatic t_cal;
		unlock(16'h2300);
		wr(8'h04, 16'h0024);
		wr(8'h04, 16'h0229);
		wr(8'h04, 16'h0623);
		wr(8'h04, 16'h5959);
		rc(8'h00, 16'h2000);
		wr(8'h00, 16'h0300);
		rc(8'h04, 16'h0024);
		rc(8'h04, 16'h0229);
		rc(8'h04, 16'h0623);
		rc(8'h04, 16'h5959);
		unlock(16'ha000);
		wr(8'h00, 16'h8300);
		repeat (150) @(posedge aclk);
		rc(8'h04, 16'h0024);
		rc(8'h04, 16'h0301);
		rc(8'h04, 16'h0000);
		rc(8'h04, 16'h0000);
	endtask : t_cal
	task automatic t_clk;
		wr(8'h00, 16'h8400);
		hi_len(n);
		`CHK("high span", 64, n)
		rc(8'h00, 16'h1800, 16'h1800);
		rc(8'h04, 16'h0000, 16'h0000);
		rd_prev = rd_last;
		rc(8'h04, 16'h0000, 16'h0000);
		`CHK("double read", rd_prev, rd_last)
		unlock(16'ha401);
		wr(8'h04, 16'h0059, 4'h1);
		rc(8'h00, 16'h0000, 16'h0800);
		wr(8'h00, 16'h8401);
		hi_len(n);
		`CHK("trimmed span", 56, n)
		@(posedge aclk);
		external_pin_reset <= 1'h1;
		hi_len(n);
		`CHK("span in pin reset", 64, n)
		rc(8'h00, 16'h8401, 16'he7ff);
		@(posedge aclk);
		external_pin_reset <= 1'h0;
		clock_source_fuse <= 1'h0;
		hi_len(n);
		`CHK("internal span", 128, n)
		@(posedge aclk);
		clock_source_fuse <= 1'h1;
		wr(8'h00, 16'h8000);
		n = 0;
		repeat (300) @(negedge aclk) n += int'(clock_out);
		`CHK("pin off", 0, n)
	endtask : t_clk
	task automatic t_alarm;
		wr(8'h08, 16'h0200);
		wr(8'h0c, 16'h0315);
		wr(8'h0c, 16'h0410);
		wr(8'h0c, 16'h3045);
		rc(8'h08, 16'h0000);
		wr(8'h08, 16'h0200);
		rc(8'h0c, 16'h0315);
		rc(8'h0c, 16'h0410);
		n = evc;
		wr(8'h08, 16'h8401);
		repeat (400) @(posedge aclk);
		`CHK("alarm events", 2, evc - n)
		rc(8'h08, 16'h0400);
		wr(8'h08, 16'ha801);
		repeat (300) @(posedge aclk);
		`CHK("reserved events", 2, evc - n)
	endtask : t_alarm
	task automatic summarize;
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		summarize();
	end
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		t_lock();
		t_cal();
		t_clk();
		t_alarm();
		summarize();
	end
endmodule : ccrw_top_tb
bind ccrw_top ccrw_checker chk_u (.*);
`default_nettype wire
